// [core/cntarr_pkg.sv]
// constants for the counter array capture/compare/pwm block
// assumes an 8-bit special-function-register bus with one-cycle write and read strobes
package cntarr_pkg;
    localparam logic [7:0] ADDR_ARRAY0_CONTROL = 8'ha4;
    localparam logic [7:0] ADDR_ARRAY1_CONTROL = 8'hbc;
    localparam logic [7:0] ADDR_STATUS         = 8'ha5;
    localparam logic [7:0] ADDR_CNT_LOW        = 8'ha2;
    localparam logic [7:0] ADDR_CNT_HIGH       = 8'ha3;
    localparam logic [7:0] ADDR_MODE0          = 8'ha9;
    localparam logic [7:0] ADDR_CMP_LOW0       = 8'hac;
    localparam logic [7:0] ADDR_CMP_HIGH0      = 8'had;
    localparam logic [7:0] ADDR_CMP_LOW1       = 8'haf;
    localparam logic [7:0] ADDR_CMP_HIGH1      = 8'hb1;
    localparam logic [7:0] ADDR_CMP_LOW2       = 8'hb2;
    localparam logic [7:0] ADDR_CMP_HIGH2      = 8'hb3;
    localparam logic [7:0] ADDR_PERIOD         = 8'hb4;
    localparam logic [7:0] CONTROL_RESET       = 8'h00;
    localparam logic [7:0] MODE_RESET          = 8'h00;
    localparam logic [7:0] CONTROL_WMASK       = 8'h77;
    localparam int CTL_RUN      = 6;
    localparam int CTL_OVF_IE   = 5;
    localparam int CTL_IDLE_STOP = 4;
    localparam int CTL_WIDE_SEL = 2;
    localparam int MODE_IRQ_EN  = 7;
    localparam int MODE_CMP_EN  = 6;
    localparam int MODE_CAP_POS = 5;
    localparam int MODE_CAP_NEG = 4;
    localparam int MODE_MATCH   = 3;
    localparam int MODE_TOGGLE  = 2;
    localparam int STA_OVF      = 3;
    localparam int EXT_MIN_OSC_PER_CLK = 4;
    typedef enum logic [1:0] {
        CLK_PRESCALE = 2'b00,
        CLK_TIMER0   = 2'b01,
        CLK_EXTERNAL = 2'b10,
        CLK_NONE     = 2'b11
    } clk_sel_t;
    typedef enum logic [1:0] {
        PWM_OFF   = 2'b00,
        PWM_FIX8  = 2'b01,
        PWM_PROG8 = 2'b10,
        PWM_WIDE  = 2'b11
    } pwm_mode_t;
endpackage

// [core/tcm_channel.sv]
// one timer/counter module: capture, compare, toggle and pwm output
// assumes the shared counter, its tick and period-match strobe come from the array; wraps are decoded here
`timescale 1ns/1ps
module tcm_channel
    import cntarr_pkg::*;
(
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    input  wire logic        i_tick,
    input  wire logic [15:0] i_count,
    input  wire logic        i_wide10,
    input  wire logic        i_period_hit,
    input  wire logic        i_mode_wr,
    input  wire logic        i_low_wr,
    input  wire logic        i_high_wr,
    input  wire logic [7:0]  i_wdata,
    input  wire logic        i_pin,
    output logic [7:0]       o_mode,
    output logic [15:0]      o_compare,
    output logic             o_event,
    output logic             o_pin_out,
    output logic             o_pin_oe_n
);
    logic [7:0]  mode_ff;
    logic [7:0]  cmp_lo_ff;
    logic [7:0]  cmp_hi_ff;
    logic        out_ff;
    logic        pin_d_ff;
    pwm_mode_t   pmode;
    logic        match;
    logic        cap_edge;
    logic        lo_wrap;
    logic        wide_wrap;
    logic        wide_hi;
    logic [15:0] cnt_next;

    assign pmode     = pwm_mode_t'(mode_ff[1:0]);
    assign match     = mode_ff[MODE_CMP_EN] && i_tick && (i_count == {cmp_hi_ff, cmp_lo_ff});
    assign cap_edge  = (mode_ff[MODE_CAP_POS] && i_pin && !pin_d_ff)
                     || (mode_ff[MODE_CAP_NEG] && !i_pin && pin_d_ff);
    assign lo_wrap   = i_tick && (i_count[7:0] == 8'hff);
    assign wide_wrap = i_tick && (i_wide10 ? (i_count[9:0] == 10'h3ff) : (i_count == 16'hffff));
    // output is registered, so it is decided on the count that stands after this edge
    assign cnt_next  = i_tick ? (i_count + 16'h0001) : i_count;
    // upper six bits are ignored in the 10-bit setting
    assign wide_hi   = i_wide10 ? (cnt_next[9:0] >= {cmp_hi_ff[1:0], cmp_lo_ff})
                                : (cnt_next >= {cmp_hi_ff, cmp_lo_ff});

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            pin_d_ff <= 1'b0;
        else
            pin_d_ff <= i_pin;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            mode_ff <= MODE_RESET;
        else if (i_mode_wr)
            mode_ff <= i_wdata;
        else if (i_low_wr)
            mode_ff[MODE_CMP_EN] <= 1'b0;
        else if (i_high_wr)
            mode_ff[MODE_CMP_EN] <= 1'b1;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
        begin
            cmp_lo_ff <= 8'h00;
            cmp_hi_ff <= 8'h00;
        end
        else if (cap_edge)
        begin
            cmp_lo_ff <= i_count[7:0];
            cmp_hi_ff <= i_count[15:8];
        end
        else
        begin
            if (i_low_wr)
                cmp_lo_ff <= i_wdata;
            else if ((pmode == PWM_FIX8 && lo_wrap)
                     || (pmode == PWM_PROG8 && i_period_hit))
                cmp_lo_ff <= cmp_hi_ff;
            if (i_high_wr)
                cmp_hi_ff <= i_wdata;
        end
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            out_ff <= 1'b0;
        else if (!mode_ff[MODE_CMP_EN] && pmode != PWM_OFF)
            out_ff <= 1'b0;
        else
            unique case (pmode)
                PWM_OFF:
                    if (mode_ff[MODE_TOGGLE] && match)
                        out_ff <= !out_ff;
                PWM_FIX8, PWM_PROG8:
                    if (lo_wrap || i_period_hit)
                        out_ff <= (cmp_hi_ff == 8'h00);
                    else
                        out_ff <= (cnt_next[7:0] >= cmp_lo_ff);
                PWM_WIDE:
                    out_ff <= wide_hi;
            endcase
    end

    // pwm pin reflects compare each cycle, so 0000h gives full duty
    assign o_pin_out  = out_ff;
    assign o_pin_oe_n = !(pmode != PWM_OFF || mode_ff[MODE_TOGGLE]);
    assign o_mode     = mode_ff;
    assign o_compare  = {cmp_hi_ff, cmp_lo_ff};
    assign o_event    = (mode_ff[MODE_MATCH] && match && pmode == PWM_OFF) || cap_edge;

    chk_capture_loads: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        cap_edge |=> o_compare == $past(i_count))
        else $error("capture did not load counter");
    chk_low_write_stops: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_low_wr && !i_mode_wr) |=> !mode_ff[MODE_CMP_EN])
        else $error("low write kept comparator on");
    chk_high_write_arms: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_high_wr && !i_mode_wr && !i_low_wr) |=> mode_ff[MODE_CMP_EN])
        else $error("high write left comparator off");
    chk_toggle_flip: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (pmode == PWM_OFF && mode_ff[MODE_TOGGLE] && match) |=> o_pin_out != $past(o_pin_out))
        else $error("toggle missed");
    chk_fix8_reload: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (pmode == PWM_FIX8 && lo_wrap && !i_low_wr && !cap_edge)
        |=> cmp_lo_ff == $past(cmp_hi_ff))
        else $error("duty not reloaded");
    chk_pwm_zero_duty: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (pmode != PWM_OFF && !mode_ff[MODE_CMP_EN]) |=> !o_pin_out)
        else $error("disabled pwm high");
    chk_pulse_start_low: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (mode_ff[MODE_CMP_EN] && (pmode == PWM_FIX8 || pmode == PWM_PROG8) && lo_wrap)
        |=> o_pin_out == ($past(cmp_hi_ff) == 8'h00))
        else $error("pulse start not low");
    chk_wide_high: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (mode_ff[MODE_CMP_EN] && pmode == PWM_WIDE && !wide_wrap && wide_hi) |=> o_pin_out)
        else $error("wide pwm not high");
    cov_capture: cover property (@(posedge i_clk_sys) disable iff (i_rst) cap_edge);
    cov_toggle: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        mode_ff[MODE_TOGGLE] && match);
    cov_fix8: cover property (@(posedge i_clk_sys) disable iff (i_rst)
        pmode == PWM_FIX8 && lo_wrap);
endmodule // tcm_channel

// [core/counter_array.sv]
// one counter array: shared 16-bit counter, control, period and three channels
// assumes a special-function-register bus: one-cycle i_sfr_wr/i_sfr_rd, 8-bit address
`timescale 1ns/1ps
module counter_array
    import cntarr_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic       i_rst,
    input  wire logic       i_sfr_wr,
    input  wire logic       i_sfr_rd,
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic [7:0] i_sfr_wdata,
    input  wire logic       i_prescale_tick,
    input  wire logic       i_timer0_ovf,
    input  wire logic       i_ext_clk,
    input  wire logic       i_cpu_idle,
    input  wire logic [2:0] i_module_pin,
    output logic [7:0]      o_sfr_rdata,
    output logic [2:0]      o_module_pin,
    output logic [2:0]      o_module_pin_oe_n,
    output logic            o_irq
);
    logic [7:0]  ctrl_ff;
    logic [15:0] count_ff;
    logic [7:0]  period_ff;
    logic [7:0]  period_act_ff;
    logic [3:0]  status_ff;
    logic [7:0]  rdata_ff;
    logic        ext_d_ff;
    logic        tick;
    logic        src_tick;
    logic        period_hit;
    logic        prog_mode;
    logic        ovf_evt;
    logic [2:0]  evt;
    logic [7:0]  mode [3];
    logic [15:0] cmp  [3];

    function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
        hit = i_sfr_wr && (a == b);
    endfunction

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            ext_d_ff <= 1'b0;
        else
            ext_d_ff <= i_ext_clk;
    end

    // external pin counted on rising edge; it must run at no more than a quarter of the clock
    always_comb
    begin
        unique case (clk_sel_t'(ctrl_ff[1:0]))
            CLK_PRESCALE: src_tick = i_prescale_tick;
            CLK_TIMER0:   src_tick = i_timer0_ovf;
            CLK_EXTERNAL: src_tick = i_ext_clk && !ext_d_ff;
            CLK_NONE:     src_tick = 1'b0;
        endcase
    end

    assign tick = src_tick && ctrl_ff[CTL_RUN]
                  && !(i_cpu_idle && ctrl_ff[CTL_IDLE_STOP]);
    assign prog_mode  = (mode[0][1:0] == PWM_PROG8) || (mode[1][1:0] == PWM_PROG8)
                        || (mode[2][1:0] == PWM_PROG8);
    assign period_hit = prog_mode && tick && (count_ff[7:0] == period_act_ff);
    assign ovf_evt    = tick && (ctrl_ff[CTL_WIDE_SEL] ? (count_ff[9:0] == 10'h3ff)
                                                       : (count_ff == 16'hffff));

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            ctrl_ff <= CONTROL_RESET;
        else if (hit(i_sfr_addr, ADDR_ARRAY0_CONTROL))
            ctrl_ff <= i_sfr_wdata & CONTROL_WMASK;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            period_ff <= 8'h00;
        else if (hit(i_sfr_addr, ADDR_PERIOD))
            period_ff <= i_sfr_wdata;
    end

    // period is buffered and reloaded at each period match with the duty values
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            period_act_ff <= 8'h00;
        else if (period_hit || !prog_mode)
            period_act_ff <= period_ff;
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            count_ff <= 16'h0000;
        else if (hit(i_sfr_addr, ADDR_CNT_LOW))
            count_ff[7:0] <= i_sfr_wdata;
        else if (hit(i_sfr_addr, ADDR_CNT_HIGH))
            count_ff[15:8] <= i_sfr_wdata;
        else if (period_hit)
            count_ff <= 16'h0000;
        else if (tick)
            count_ff <= count_ff + 16'h0001;
    end

    // set beats clear: an event in the clearing write cycle is kept
    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            status_ff <= 4'h0;
        else if (hit(i_sfr_addr, ADDR_STATUS))
            status_ff <= {i_sfr_wdata[STA_OVF], i_sfr_wdata[2:0]} | {ovf_evt, evt};
        else
            status_ff <= status_ff | {ovf_evt, evt};
    end

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            o_irq <= 1'b0;
        else
            o_irq <= (status_ff[3] && ctrl_ff[CTL_OVF_IE])
                     || (status_ff[0] && mode[0][MODE_IRQ_EN])
                     || (status_ff[1] && mode[1][MODE_IRQ_EN])
                     || (status_ff[2] && mode[2][MODE_IRQ_EN]);
    end

    localparam logic [7:0] LOW_ADDR  [3] = '{ADDR_CMP_LOW0, ADDR_CMP_LOW1, ADDR_CMP_LOW2};
    localparam logic [7:0] HIGH_ADDR [3] = '{ADDR_CMP_HIGH0, ADDR_CMP_HIGH1, ADDR_CMP_HIGH2};

    genvar g;
    generate
        for (g = 0; g < 3; g++)
        begin : g_tcm
            tcm_channel u_tcm (
                .i_clk_sys    (i_clk_sys),
                .i_rst        (i_rst),
                .i_tick       (tick),
                .i_count      (count_ff),
                .i_wide10     (ctrl_ff[CTL_WIDE_SEL]),
                .i_period_hit (period_hit),
                .i_mode_wr    (hit(i_sfr_addr, ADDR_MODE0 + 8'(g))),
                .i_low_wr     (hit(i_sfr_addr, LOW_ADDR[g])),
                .i_high_wr    (hit(i_sfr_addr, HIGH_ADDR[g])),
                .i_wdata      (i_sfr_wdata),
                .i_pin        (i_module_pin[g]),
                .o_mode       (mode[g]),
                .o_compare    (cmp[g]),
                .o_event      (evt[g]),
                .o_pin_out    (o_module_pin[g]),
                .o_pin_oe_n   (o_module_pin_oe_n[g])
            );
        end
    endgenerate

    always_ff @(posedge i_clk_sys or posedge i_rst)
    begin
        if (i_rst)
            rdata_ff <= 8'h00;
        else if (i_sfr_rd)
            unique case (i_sfr_addr)
                ADDR_ARRAY0_CONTROL: rdata_ff <= ctrl_ff;
                ADDR_STATUS:         rdata_ff <= {4'h0, status_ff[3], status_ff[2:0]};
                ADDR_CNT_LOW:        rdata_ff <= count_ff[7:0];
                ADDR_CNT_HIGH:       rdata_ff <= count_ff[15:8];
                ADDR_PERIOD:         rdata_ff <= period_ff;
                ADDR_MODE0:          rdata_ff <= mode[0];
                ADDR_MODE0 + 8'h01:  rdata_ff <= mode[1];
                ADDR_MODE0 + 8'h02:  rdata_ff <= mode[2];
                ADDR_CMP_LOW0:       rdata_ff <= cmp[0][7:0];
                ADDR_CMP_HIGH0:      rdata_ff <= cmp[0][15:8];
                ADDR_CMP_LOW1:       rdata_ff <= cmp[1][7:0];
                ADDR_CMP_HIGH1:      rdata_ff <= cmp[1][15:8];
                ADDR_CMP_LOW2:       rdata_ff <= cmp[2][7:0];
                ADDR_CMP_HIGH2:      rdata_ff <= cmp[2][15:8];
                default:             rdata_ff <= 8'h00;
            endcase
    end
    assign o_sfr_rdata = rdata_ff;

    chk_run_gates_count: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (!ctrl_ff[CTL_RUN] && !i_sfr_wr) |=> count_ff == $past(count_ff))
        else $error("counter moved while stopped");
    chk_idle_stop: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (i_cpu_idle && ctrl_ff[CTL_IDLE_STOP]) |-> !tick)
        else $error("counter ticked in idle");
    chk_period_clear: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (period_hit && !i_sfr_wr) |=> count_ff == 16'h0000)
        else $error("period match did not clear");
    chk_ovf_irq: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (status_ff[3] && ctrl_ff[CTL_OVF_IE]) |=> o_irq)
        else $error("overflow interrupt missing");
    chk_flag_sticky: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        (status_ff[0] && !hit(i_sfr_addr, ADDR_STATUS)) |=> status_ff[0])
        else $error("flag dropped");
    chk_ovf_sets: assert property (@(posedge i_clk_sys) disable iff (i_rst)
        ovf_evt |=> status_ff[3])
        else $error("overflow flag not set");
    cov_overflow_irq: cover property (@(posedge i_clk_sys) disable iff (i_rst) o_irq);
    cov_period: cover property (@(posedge i_clk_sys) disable iff (i_rst) period_hit);
endmodule // counter_array

// [verification/sfr_host.sv]
// host cpu model driving the special-function-register bus of one counter array
// assumes strobes are sampled on the rising edge of i_clk_sys and read data lands one cycle later
`timescale 1ns/1ps
module sfr_host
    import cntarr_pkg::*;
(
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_rdata,
    output logic            o_wr,
    output logic            o_rd,
    output logic [7:0]      o_addr,
    output logic [7:0]      o_wdata
);
    initial
    begin
        o_wr    = 1'b0;
        o_rd    = 1'b0;
        o_addr  = 8'h00;
        o_wdata = 8'h00;
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk_sys);
        o_wr    <= 1'b1;
        o_addr  <= a;
        o_wdata <= d;
        @(posedge i_clk_sys);
        o_wr    <= 1'b0;
        // released bus shows the inverse so a stale value cannot pass
        o_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk_sys);
        o_rd   <= 1'b1;
        o_addr <= a;
        @(posedge i_clk_sys);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask
    // low byte first: the low write disarms the comparator, the high write re-arms it
    task automatic wr_cmp(input int ch, input logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        lo = (ch == 0) ? ADDR_CMP_LOW0 : (ch == 1) ? ADDR_CMP_LOW1 : ADDR_CMP_LOW2;
        hi = (ch == 0) ? ADDR_CMP_HIGH0 : (ch == 1) ? ADDR_CMP_HIGH1 : ADDR_CMP_HIGH2;
        wr(lo, v[7:0]);
        wr(hi, v[15:8]);
    endtask
endmodule // sfr_host

// [verification/tb_top.sv]
// self-checking bench for one counter array, driven through the host model
// assumes a 40 MHz system clock and no second clock domain
`timescale 1ns/1ps
module tb_top
    import cntarr_pkg::*;
;
    localparam logic [7:0] CTL = ADDR_ARRAY0_CONTROL;
    localparam logic [7:0] STA = ADDR_STATUS;
    localparam logic [7:0] MD0 = ADDR_MODE0;
    logic       clk;
    logic       rst;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       pre;
    logic       t0;
    logic       ext;
    logic       idle;
    logic [2:0] pin;
    logic [7:0] rdata;
    logic [2:0] pout;
    logic [2:0] poe_n;
    logic       irq;
    logic [7:0] d;
    int         hi [3];
    int         num_errors;
    int         n_checks;
    counter_array dut_u (.i_clk_sys(clk), .i_rst(rst), .i_sfr_wr(wr), .i_sfr_rd(rd),
        .i_sfr_addr(addr), .i_sfr_wdata(wdata), .i_prescale_tick(pre), .i_timer0_ovf(t0),
        .i_ext_clk(ext), .i_cpu_idle(idle), .i_module_pin(pin), .o_sfr_rdata(rdata),
        .o_module_pin(pout), .o_module_pin_oe_n(poe_n), .o_irq(irq));
    sfr_host host_u (.i_clk_sys(clk), .i_rdata(rdata), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wdata));
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, d);
        chk(nm, {8'h00, e}, {8'h00, d});
    endtask
    // ext clock gets four system cycles per count, the fastest rate it may run
    task automatic tick(input int s, input int n);
        repeat (n)
        begin
            @(posedge clk);
            if (s == 0) pre <= 1'b1;
            if (s == 1) t0 <= 1'b1;
            if (s == 2) ext <= 1'b1;
            @(posedge clk);
            pre <= 1'b0;
            t0  <= 1'b0;
            ext <= 1'b0;
            repeat (2) @(posedge clk);
        end
    endtask
    task automatic setcnt(input logic [15:0] v);
        host_u.wr(CTL, 8'h00);
        host_u.wr(ADDR_CNT_LOW, v[7:0]);
        host_u.wr(ADDR_CNT_HIGH, v[15:8]);
    endtask
    task automatic meas(input int n);
        for (int i = 0; i < 3; i++) hi[i] = 0;
        repeat (n)
        begin
            @(negedge clk);
            for (int i = 0; i < 3; i++) hi[i] += int'(pout[i]);
        end
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        num_errors++;
        print_verdict();
    end
    initial
    begin
        {rst, pre, t0, ext, idle, pin} = 8'h80;
        num_errors = 0;
        n_checks = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rchk("ctl reset", CTL, CONTROL_RESET);
        rchk("sta reset", STA, 8'h00);
        rchk("mode reset", MD0, MODE_RESET);
        rchk("unmapped", 8'h80, 8'h00);
        chk("oe reset", 16'h0007, {13'h0, poe_n});
        host_u.wr(CTL, 8'hff);
        rchk("ctl mask", CTL, 8'h77);
        for (int s = 0; s < 3; s++)
        begin
            setcnt(16'h0000);
            host_u.wr(CTL, 8'h40 | 8'(s));
            tick(s, 5);
            host_u.wr(CTL, 8'(s));
            tick(s, 2);
            rchk("count src", ADDR_CNT_LOW, 8'h05);
        end
        setcnt(16'h0000);
        host_u.wr(CTL, 8'h50);
        idle <= 1'b1;
        tick(0, 3);
        idle <= 1'b0;
        tick(0, 2);
        host_u.wr(CTL, 8'h40);
        idle <= 1'b1;
        tick(0, 3);
        idle <= 1'b0;
        host_u.wr(CTL, 8'h00);
        rchk("count idle", ADDR_CNT_LOW, 8'h05);
        setcnt(16'hffff);
        host_u.wr(CTL, 8'h60);
        tick(0, 1);
        rchk("ovf flag", STA, 8'h08);
        chk("ovf irq", 16'h0001, {15'h0, irq});
        host_u.wr(CTL, 8'h00);
        repeat (3) @(posedge clk);
        chk("ovf irq off", 16'h0000, {15'h0, irq});
        host_u.wr(STA, 8'h00);
        setcnt(16'h0000);
        host_u.wr(MD0, 8'h88);
        host_u.wr_cmp(0, 16'h0003);
        host_u.wr(CTL, 8'h40);
        // the match needs a count pulse while the counter stands at the compare value
        tick(0, 4);
        host_u.wr(CTL, 8'h00);
        rchk("match flag", STA, 8'h01);
        chk("match irq", 16'h0001, {15'h0, irq});
        host_u.wr(STA, 8'h00);
        repeat (3) @(posedge clk);
        chk("irq cleared", 16'h0000, {15'h0, irq});
        host_u.wr(MD0, 8'h20);
        setcnt(16'h1234);
        pin[0] <= 1'b1;
        repeat (4) @(posedge clk);
        rchk("cap low", ADDR_CMP_LOW0, 8'h34);
        rchk("cap high", ADDR_CMP_HIGH0, 8'h12);
        rchk("cap flag", STA, 8'h01);
        host_u.wr(STA, 8'h00);
        setcnt(16'h0000);
        host_u.wr(MD0, 8'h44);
        host_u.wr_cmp(0, 16'h0005);
        host_u.wr(CTL, 8'h40);
        tick(0, 6);
        host_u.wr(CTL, 8'h00);
        chk("toggle", 16'h0001, {15'h0, pout[0]});
        chk("toggle oe", 16'h0000, {15'h0, poe_n[0]});
        // fixed 8-bit pwm, counter advancing every cycle
        setcnt(16'h0000);
        host_u.wr(MD0, 8'h41);
        host_u.wr_cmp(0, 16'h8080);
        host_u.wr(CTL, 8'h40);
        pre <= 1'b1;
        repeat (300) @(posedge clk);
        meas(256);
        chk("pwm8 duty", 16'd128, 16'(hi[0]));
        host_u.wr(ADDR_CMP_HIGH0, 8'hc0);
        repeat (300) @(posedge clk);
        meas(256);
        chk("pwm8 reload", 16'd64, 16'(hi[0]));
        host_u.wr(ADDR_CMP_LOW0, 8'h80);
        rchk("cmp off", MD0, 8'h01);
        repeat (300) @(posedge clk);
        meas(256);
        chk("pwm8 zero", 16'd0, 16'(hi[0]));
        host_u.wr(ADDR_CMP_HIGH0, 8'h80);
        rchk("cmp on", MD0, 8'h41);
        setcnt(16'h0000);
        host_u.wr(MD0, 8'h42);
        host_u.wr(MD0 + 8'h01, 8'h42);
        host_u.wr(MD0 + 8'h02, 8'h00);
        host_u.wr(ADDR_PERIOD, 8'h3f);
        host_u.wr_cmp(0, 16'h1010);
        host_u.wr_cmp(1, 16'h2020);
        host_u.wr(CTL, 8'h40);
        repeat (300) @(posedge clk);
        meas(256);
        chk("prog ch0", 16'd192, 16'(hi[0]));
        chk("prog ch1", 16'd128, 16'(hi[1]));
        chk("prog oe", 16'h0004, {13'h0, poe_n});
        setcnt(16'h0000);
        for (int c = 0; c < 3; c++) host_u.wr(MD0 + 8'(c), 8'h43);
        host_u.wr_cmp(0, 16'h0300);
        host_u.wr_cmp(1, 16'hfd00);
        host_u.wr_cmp(2, 16'h0000);
        host_u.wr(CTL, 8'h44);
        repeat (1100) @(posedge clk);
        meas(1024);
        chk("wide ch0", 16'd256, 16'(hi[0]));
        chk("wide ch1", 16'd768, 16'(hi[1]));
        chk("wide ch2", 16'd1024, 16'(hi[2]));
        pre <= 1'b0;
        print_verdict();
    end
endmodule // tb_top
